// ===== verification/host_model.sv
// Host controller model issuing commands, block writes and reads
`timescale 1ns/10ps
`default_nettype none
module host_model (
	input  wire logic        ref_clk_in,
	output logic             cmd_valid_out,
	output logic [5:0]       cmd_index_out,
	output logic [3:0]       cmd_function_out,
	output logic [31:0]      cmd_addr_out,
	output logic             write_block_out,
	output logic             write_active_out,
	output logic [31:0]      write_addr_out,
	output logic             read_block_out,
	output logic [31:0]      read_addr_out
);
	initial begin
		{cmd_valid_out, write_block_out, write_active_out, read_block_out} = 4'h0;
		{cmd_index_out, cmd_function_out, cmd_addr_out} = '0;
		write_addr_out = '0;
		read_addr_out = '0;
	end
	task automatic cmd(input logic [5:0] idx, input logic [3:0] fn, input logic [31:0] a);
		@(negedge ref_clk_in);
		{cmd_index_out, cmd_function_out, cmd_addr_out} = {idx, fn, a};
		cmd_valid_out = 1'b1;
		@(negedge ref_clk_in);
		cmd_valid_out = 1'b0;
		cmd_addr_out = ~a;
	endtask : cmd
	// Blocks go out back to back in address order
	task automatic wr(input logic [31:0] a, input int n);
		for (int i = 0; i < n; i++) begin
			@(negedge ref_clk_in);
			{write_active_out, write_block_out} = 2'b11;
			write_addr_out = a + 32'(i);
		end
		@(negedge ref_clk_in);
		{write_active_out, write_block_out} = 2'b00;
		write_addr_out = ~write_addr_out;
	endtask : wr
	task automatic rd(input logic [31:0] a);
		@(negedge ref_clk_in);
		read_block_out = 1'b1;
		read_addr_out = a;
		@(negedge ref_clk_in);
		read_block_out = 1'b0;
		read_addr_out = ~a;
		@(negedge ref_clk_in);
	endtask : rd
endmodule : host_model
`default_nettype wire

// ===== verification/stream_record_timing_assertions.sv
// Port-level checks for the stream recording timing block
`timescale 1ns/10ps
`default_nettype none
module stream_record_timing_assertions
	import stream_record_pkg::*;
(
	input wire logic        ref_clk_in,
	input wire logic        reset_n_in,
	input wire logic        cmd_valid_in,
	input wire logic [5:0]  cmd_index_in,
	input wire logic [3:0]  cmd_function_in,
	input wire logic [31:0] cmd_addr_in,
	input wire logic        media_done_in,
	input wire logic        write_block_in,
	input wire logic [31:0] write_addr_in,
	input wire logic        read_block_in,
	input wire logic [31:0] read_addr_in,
	input wire logic        busy_out,
	input wire logic        recording_out,
	input wire logic        rd_written_out,
	input wire logic        rd_undefined_out,
	input wire logic [31:0] write_ptr_out,
	input wire logic        sub_invalid_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!reset_n_in);
	sequence s_free_sel;
		cmd_valid_in && cmd_index_in == 6'h14 && cmd_function_in == FN_FREE;
	endsequence
	sequence s_done_early;
		media_done_in && busy_out && !cmd_valid_in && !write_block_in;
	endsequence
	property p_busy_rise;
		cmd_valid_in && cmd_index_in == 6'h14 |=> busy_out;
	endproperty
	property p_busy_release;
		s_done_early |-> ##[1:2] !busy_out;
	endproperty
	property p_free_active;
		s_free_sel |=> recording_out && write_ptr_out == ($past(cmd_addr_in) & 32'hfffe0000);
	endproperty
	property p_seq_step;
		recording_out && write_block_in && !busy_out && !cmd_valid_in &&
			write_addr_in == write_ptr_out && write_addr_in[16:0] != 17'h1ffff
			|=> write_ptr_out == $past(write_ptr_out) + 32'h1;
	endproperty
	property p_violate;
		cmd_valid_in && (cmd_index_in == 6'h38 || cmd_index_in[5:2] == 4'hf) |=> !recording_out;
	endproperty
	property p_rd_written;
		read_block_in && recording_out && read_addr_in < write_ptr_out &&
			read_addr_in[31:17] == write_ptr_out[31:17] |=> rd_written_out;
	endproperty
	property p_rd_undef;
		read_block_in && recording_out && read_addr_in >= write_ptr_out &&
			read_addr_in[31:17] == write_ptr_out[31:17] |=> rd_undefined_out && !rd_written_out;
	endproperty
	property p_stop_inval;
		cmd_valid_in && cmd_index_in == 6'h0c && recording_out && write_ptr_out[9:0] != 10'h0
			|=> sub_invalid_out;
	endproperty
	a_busy_rise: assert property (p_busy_rise) else $error("busy not raised");
	a_busy_release: assert property (p_busy_release) else $error("busy held");
	a_free_active: assert property (p_free_active) else $error("free select");
	a_seq_step: assert property (p_seq_step) else $error("pointer step");
	a_violate: assert property (p_violate) else $error("recording kept");
	a_rd_written: assert property (p_rd_written) else $error("written read");
	a_rd_undef: assert property (p_rd_undef) else $error("unwritten read");
	a_stop_inval: assert property (p_stop_inval) else $error("stop not marked");
endmodule : stream_record_timing_assertions
bind stream_record_timing stream_record_timing_assertions stream_record_timing_assertions_i (
	.ref_clk_in, .reset_n_in, .cmd_valid_in, .cmd_index_in, .cmd_function_in, .cmd_addr_in,
	.media_done_in, .write_block_in, .write_addr_in, .read_block_in, .read_addr_in, .busy_out,
	.recording_out, .rd_written_out, .rd_undefined_out, .write_ptr_out, .sub_invalid_out);
`default_nettype wire

// ===== verification/tb.sv
// Self-checking bench for the stream recording timing block
`timescale 1ns/10ps
`default_nettype none
module tb
	import stream_record_pkg::*;
;
	localparam logic [27:0] LIM = 28'd20;
	localparam int SUB = 32768;
	logic ref_clk_in = 1'b0, reset_n_in = 1'b0, media_done_in = 1'b0, ext_capacity_in = 1'b0;
	logic wr_valid_in = 1'b0, media_ready_in = 1'b0, fs_read_active_in = 1'b0;
	logic read_ok_out, fs_read_late_out;
	logic [31:0] worst_read_period_out;
	logic [31:0] wr_data_in = '0, rnd = 32'hf1bc, srnd = 32'hf1bc, base;
	logic cmd_valid_in, write_block_in, write_active_in, read_block_in;
	logic [5:0] cmd_index_in;
	logic [3:0] cmd_function_in;
	logic [31:0] cmd_addr_in, write_addr_in, read_addr_in, write_ptr_out, media_data_out;
	logic [31:0] worst_write_period_out;
	logic wr_ready_out, media_valid_out, busy_out, recording_out, rd_written_out;
	logic rd_undefined_out, sub_invalid_out, class_ok_out;
	logic [4:0] class_unit_size_field_out;
	logic [1:0] stall = 2'd0;
	logic [31:0] exp_q[$];
	record_fn_e fns[7] = '{FN_START, FN_DIR, FN_INFO, FN_PAUSE, FN_CONT, FN_RELEASE, FN_FREE};
	logic [5:0] viol[5] = '{6'h38, 6'h3c, 6'h3d, 6'h3e, 6'h3f};
	int fails = 0, samples_checked = 0, cycles = 0, n;

	always #5 ref_clk_in = ~ref_clk_in;

	stream_record_timing #(.START_CYCLES(LIM), .DIR_CYCLES(LIM), .DIR_WR_HC_CYC(LIM),
		.DIR_WR_XC_CYC(28'd30), .INFO_CYCLES(LIM), .INFO_WR_CYCLES(LIM), .PAUSE_CYCLES(LIM),
		.CONT_CYCLES(LIM), .FREE_CYCLES(LIM), .RELEASE_CYCLES(LIM), .FS_READ_CYCLES(LIM))
	stream_record_timing_i (.ref_clk_in, .reset_n_in, .cmd_valid_in, .cmd_index_in,
		.cmd_function_in, .cmd_addr_in, .ext_capacity_in, .media_done_in, .write_block_in,
		.write_addr_in, .write_active_in, .read_block_in, .read_addr_in, .read_active_in(1'b0),
		.fs_unit_in(1'b0), .fs_read_active_in, .wr_data_in, .wr_valid_in, .wr_ready_out,
		.media_data_out, .media_valid_out, .media_ready_in, .busy_out, .recording_out,
		.rd_written_out, .rd_undefined_out, .write_ptr_out, .sub_invalid_out,
		.worst_write_period_out, .worst_read_period_out, .class_ok_out, .read_ok_out,
		.fs_read_late_out, .class_unit_size_field_out);

	host_model host_model_i (.ref_clk_in, .cmd_valid_out(cmd_valid_in),
		.cmd_index_out(cmd_index_in), .cmd_function_out(cmd_function_in),
		.cmd_addr_out(cmd_addr_in), .write_block_out(write_block_in),
		.write_active_out(write_active_in), .write_addr_out(write_addr_in),
		.read_block_out(read_block_in), .read_addr_out(read_addr_in));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task automatic check(input logic ok, input string what);
		samples_checked++;
		if (ok !== 1'b1) begin
			fails++;
			$display("BAD %0t %s", $time, what);
		end
	endtask : check

	task automatic results();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : results

	task automatic busy_len(output int k);
		k = 0;
		while (busy_out === 1'b1 && k < 200) begin
			k++;
			@(negedge ref_clk_in);
		end
	endtask : busy_len

	task automatic op(input logic [3:0] fn, input logic [31:0] a, input int exp);
		host_model_i.cmd(6'h14, fn, a);
		busy_len(n);
		check(n == exp, "busy length");
	endtask : op

	// Word is held until the buffer takes it
	task automatic push(input logic [31:0] d);
		int k;
		k = 0;
		wr_data_in = d;
		wr_valid_in = 1'b1;
		while (wr_ready_out !== 1'b1 && k < 500) begin
			@(negedge ref_clk_in);
			#1;
			k++;
		end
		@(negedge ref_clk_in);
		#1;
	endtask : push

	always @(negedge ref_clk_in) begin
		srnd = lfsr(srnd);
		media_ready_in <= stall == 2'd0 || (stall == 2'd1 && srnd[0]);
	end

	always @(posedge ref_clk_in) begin
		cycles++;
		if (cycles > 60000) begin
			fails++;
			results();
		end
		if (media_valid_out === 1'b1 && media_ready_in === 1'b1) begin
			if (exp_q.size() == 0) check(1'b0, "unexpected word");
			else check(media_data_out === exp_q.pop_front(), "buffer order");
		end
		if (wr_valid_in && wr_ready_out === 1'b1) exp_q.push_back(wr_data_in);
	end

	initial begin
		repeat (3) @(negedge ref_clk_in);
		reset_n_in = 1'b1;
		check(busy_out === 1'b0 && recording_out === 1'b0 && wr_ready_out === 1'b1, "reset");
		check(class_unit_size_field_out === 5'h0d, "unit size field");
		$display("test reset done");
		foreach (fns[i]) op(fns[i], rnd, 20);
		for (int e = 0; e < 2; e++) begin
			ext_capacity_in = e[0];
			op(FN_DIR, rnd, 20);
			host_model_i.wr(32'h40, 1);
			busy_len(n);
			check(n == 20 + 10 * e, "dir write busy");
		end
		op(FN_INFO, rnd, 20);
		host_model_i.wr(32'h41, 1);
		busy_len(n);
		check(n == 20, "info write busy");
		$display("test busy limits done");
		rnd = lfsr(rnd);
		base = rnd & 32'hfffe0000;
		op(FN_FREE, rnd, 20);
		check(recording_out === 1'b1 && write_ptr_out === base, "free select");
		host_model_i.wr(base, SUB);
		check(write_ptr_out === base + SUB, "sequential fill");
		check(worst_write_period_out >= SUB + 16 && worst_write_period_out <= SUB + 64
			&& class_ok_out === 1'b1, "write period");
		host_model_i.rd(base + 5);
		check(rd_written_out === 1'b1, "read of written block");
		host_model_i.rd(base + SUB + 9);
		check(rd_undefined_out === 1'b1 && rd_written_out === 1'b0, "read ahead");
		host_model_i.wr(base + SUB, 100);
		host_model_i.cmd(6'h0c, 4'h0, 32'h0);
		check(sub_invalid_out === 1'b1, "stop mid unit");
		$display("test recording done");
		foreach (viol[i]) begin
			op(FN_FREE, base, 20);
			host_model_i.cmd(viol[i], 4'h0, 32'h0);
			check(recording_out === 1'b0, "violating command");
		end
		op(FN_FREE, base, 20);
		host_model_i.wr(base + 3, 1);
		check(recording_out === 1'b0, "skipped block");
		host_model_i.cmd(6'h14, FN_START, 32'h0);
		repeat (3) @(negedge ref_clk_in);
		media_done_in = 1'b1;
		@(negedge ref_clk_in);
		media_done_in = 1'b0;
		busy_len(n);
		check(n <= 1, "early release");
		$display("test violations done");
		check(read_ok_out === 1'b1 && worst_read_period_out === 32'h0, "no reads measured");
		fs_read_active_in = 1'b1;
		repeat (10) @(negedge ref_clk_in);
		fs_read_active_in = 1'b0;
		@(negedge ref_clk_in);
		check(fs_read_late_out === 1'b0, "fs read in time");
		fs_read_active_in = 1'b1;
		repeat (25) @(negedge ref_clk_in);
		fs_read_active_in = 1'b0;
		@(negedge ref_clk_in);
		check(fs_read_late_out === 1'b1, "fs read late");
		$display("test fs read done");
		stall = 2'd2;
		@(negedge ref_clk_in);
		#1;
		push(rnd);
		push(~rnd);
		repeat (2) @(negedge ref_clk_in);
		check(wr_ready_out === 1'b0 && media_valid_out === 1'b1, "buffer full");
		stall = 2'd1;
		#1;
		for (int i = 0; i < 40; i++) begin
			rnd = lfsr(rnd);
			push(rnd);
		end
		wr_valid_in = 1'b0;
		stall = 2'd0;
		repeat (5) @(negedge ref_clk_in);
		check(exp_q.size() == 0 && media_valid_out === 1'b0, "buffer drained");
		$display("test buffer done");
		results();
	end
endmodule : tb
`default_nettype wire

// ===== verilog/stream_record_map.svh
// Constants for the stream recording timing block
`ifndef STREAM_RECORD_MAP_SVH
`define STREAM_RECORD_MAP_SVH

`define SR_CLK_HZ           64'd100000000
`define SR_START_MS         64'd1000
`define SR_DIR_MS           64'd10
`define SR_DIR_WR_HC_MS     64'd250
`define SR_DIR_WR_XC_MS     64'd500
`define SR_INFO_MS          64'd10
`define SR_INFO_WR_MS       64'd250
`define SR_PAUSE_MS         64'd250
`define SR_CONT_MS          64'd250
`define SR_FREE_MS          64'd250
`define SR_RELEASE_MS       64'd50
`define SR_FS_READ_MS       64'd20
`define SR_MS_CYC(ms)       (((ms) * `SR_CLK_HZ) / 64'd1000)

`define SR_CMD_RECORD       6'h14
`define SR_CMD_STOP         6'h0c
`define SR_CMD_RD_SINGLE    6'h11
`define SR_CMD_RD_MULTI     6'h12
`define SR_CMD_GEN          6'h38
`define SR_CMD_VEND_LO      6'h3c

`define SR_REC_BLK_BITS     10
`define SR_SUB_BLK_BITS     15
`define SR_UNIT_BLK_BITS    17
`define SR_SUB_MB           64'd16
`define SR_UNIT_SIZE_CODE   5'h0d
`define SR_UNIT_SIZE_MAX    5'h1f
`define SR_CLASS_VALUE      64'd10
`endif

// ===== verilog/stream_record_pkg.sv
// Types for the stream recording timing block
package stream_record_pkg;
	typedef enum logic [3:0] {
		FN_START   = 4'h0,
		FN_DIR     = 4'h1,
		FN_INFO    = 4'h4,
		FN_PAUSE   = 4'h5,
		FN_CONT    = 4'h6,
		FN_FREE    = 4'h7,
		FN_RELEASE = 4'h8
	} record_fn_e;

	typedef enum logic [1:0] {
		BUSY_IDLE,
		BUSY_HOLD
	} busy_st_e;

	typedef enum logic [1:0] {
		ASSOC_NONE,
		ASSOC_DIR,
		ASSOC_INFO
	} assoc_e;

	typedef struct packed {
		busy_st_e    st;
		logic [27:0] busy_cnt;
		logic [27:0] busy_lim;
		logic        busy_counts;
		assoc_e      assoc;
		logic        excl_write;
		logic        armed;
		logic        active;
		logic        first_sub;
		logic [31:0] unit_base;
		logic [31:0] wr_ptr;
		logic        sub_invalid;
		logic [31:0] sub_period;
		logic [31:0] worst_wr;
		logic [31:0] rd_period;
		logic        rd_invalid;
		logic [31:0] worst_rd;
		logic [27:0] fs_cnt;
		logic        fs_late;
		logic        rd_written;
		logic        rd_undefined;
		logic        class_ok;
		logic        read_ok;
	} record_state_s;

	typedef struct packed {
		logic [31:0] word0;
		logic [31:0] word1;
		logic [1:0]  count;
	} buffer_state_s;
endpackage : stream_record_pkg

// ===== verilog/stream_record_timing.sv
// Card-side stream recording control, busy timing and performance tracking
`timescale 1ns/10ps
`default_nettype none
`include "stream_record_map.svh"
module stream_record_timing
	import stream_record_pkg::*;
#(
	parameter logic [27:0] START_CYCLES    = 28'(`SR_MS_CYC(`SR_START_MS)),
	parameter logic [27:0] DIR_CYCLES      = 28'(`SR_MS_CYC(`SR_DIR_MS)),
	parameter logic [27:0] DIR_WR_HC_CYC   = 28'(`SR_MS_CYC(`SR_DIR_WR_HC_MS)),
	parameter logic [27:0] DIR_WR_XC_CYC   = 28'(`SR_MS_CYC(`SR_DIR_WR_XC_MS)),
	parameter logic [27:0] INFO_CYCLES     = 28'(`SR_MS_CYC(`SR_INFO_MS)),
	parameter logic [27:0] INFO_WR_CYCLES  = 28'(`SR_MS_CYC(`SR_INFO_WR_MS)),
	parameter logic [27:0] PAUSE_CYCLES    = 28'(`SR_MS_CYC(`SR_PAUSE_MS)),
	parameter logic [27:0] CONT_CYCLES     = 28'(`SR_MS_CYC(`SR_CONT_MS)),
	parameter logic [27:0] FREE_CYCLES     = 28'(`SR_MS_CYC(`SR_FREE_MS)),
	parameter logic [27:0] RELEASE_CYCLES  = 28'(`SR_MS_CYC(`SR_RELEASE_MS)),
	parameter logic [27:0] FS_READ_CYCLES  = 28'(`SR_MS_CYC(`SR_FS_READ_MS))
)
(
	input  wire logic        ref_clk_in,
	input  wire logic        reset_n_in,
	input  wire logic        cmd_valid_in,
	input  wire logic [5:0]  cmd_index_in,
	input  wire logic [3:0]  cmd_function_in,
	input  wire logic [31:0] cmd_addr_in,
	input  wire logic        ext_capacity_in,
	input  wire logic        media_done_in,
	input  wire logic        write_block_in,
	input  wire logic [31:0] write_addr_in,
	input  wire logic        write_active_in,
	input  wire logic        read_block_in,
	input  wire logic [31:0] read_addr_in,
	input  wire logic        read_active_in,
	input  wire logic        fs_unit_in,
	input  wire logic        fs_read_active_in,
	input  wire logic [31:0] wr_data_in,
	input  wire logic        wr_valid_in,
	output logic             wr_ready_out,
	output logic [31:0]      media_data_out,
	output logic             media_valid_out,
	input  wire logic        media_ready_in,
	output logic             busy_out,
	output logic             recording_out,
	output logic             rd_written_out,
	output logic             rd_undefined_out,
	output logic [31:0]      write_ptr_out,
	output logic             sub_invalid_out,
	output logic [31:0]      worst_write_period_out,
	output logic [31:0]      worst_read_period_out,
	output logic             class_ok_out,
	output logic             read_ok_out,
	output logic             fs_read_late_out,
	output logic [4:0]       class_unit_size_field_out
);
	localparam logic [31:0] UNIT_MASK = 32'((64'd1 << `SR_UNIT_BLK_BITS) - 64'd1);
	localparam logic [31:0] SUB_MASK  = 32'((64'd1 << `SR_SUB_BLK_BITS) - 64'd1);
	localparam logic [31:0] REC_MASK  = 32'((64'd1 << `SR_REC_BLK_BITS) - 64'd1);

	record_state_s s;
	record_state_s next_s;
	stream_word_if fill_bus ();
	stream_word_if drain_bus ();

	// Commands that end recording at once
	function automatic logic is_violating(input logic [5:0] idx);
		is_violating = (idx == `SR_CMD_GEN) || (idx >= `SR_CMD_VEND_LO);
	endfunction : is_violating

	// Busy limit for each recording-control function
	function automatic logic [27:0] fn_limit(input logic [3:0] fn);
		case (fn)
			FN_START:   fn_limit = START_CYCLES;
			FN_DIR:     fn_limit = DIR_CYCLES;
			FN_INFO:    fn_limit = INFO_CYCLES;
			FN_PAUSE:   fn_limit = PAUSE_CYCLES;
			FN_CONT:    fn_limit = CONT_CYCLES;
			FN_FREE:    fn_limit = FREE_CYCLES;
			FN_RELEASE: fn_limit = RELEASE_CYCLES;
			default:    fn_limit = 28'h0000000;
		endcase
	endfunction : fn_limit

	assign fill_bus.data   = wr_data_in;
	assign fill_bus.valid  = wr_valid_in;
	assign wr_ready_out    = fill_bus.ready;
	assign media_data_out  = drain_bus.data;
	assign media_valid_out = drain_bus.valid;
	assign drain_bus.ready = media_ready_in;

	word_buffer u_buffer (
		.ref_clk_in (ref_clk_in),
		.reset_n_in (reset_n_in),
		.fill       (fill_bus),
		.drain      (drain_bus)
	);

	assign busy_out                  = (s.st == BUSY_HOLD);
	assign recording_out             = s.active;
	assign rd_written_out            = s.rd_written;
	assign rd_undefined_out          = s.rd_undefined;
	assign write_ptr_out             = s.wr_ptr;
	assign sub_invalid_out           = s.sub_invalid;
	assign worst_write_period_out    = s.worst_wr;
	assign worst_read_period_out     = s.worst_rd;
	assign class_ok_out              = s.class_ok;
	assign read_ok_out               = s.read_ok;
	assign fs_read_late_out          = s.fs_late;
	// Fixed code, checked against the 512MB ceiling
	assign class_unit_size_field_out = (`SR_UNIT_SIZE_CODE <= `SR_UNIT_SIZE_MAX) ?
		`SR_UNIT_SIZE_CODE : `SR_UNIT_SIZE_MAX;

	always_comb begin
		logic        in_unit;
		logic [31:0] rd_off;
		next_s  = s;
		in_unit = 1'b0;
		rd_off  = 32'h00000000;

		// Busy hold, dropped on completion or at the limit
		case (s.st)
			BUSY_IDLE: begin
				next_s.busy_cnt = 28'h0000000;
			end
			BUSY_HOLD: begin
				next_s.busy_cnt = s.busy_cnt + 28'h0000001;
				if (media_done_in || s.busy_cnt + 28'h0000001 >= s.busy_lim) begin
					next_s.st          = BUSY_IDLE;
					next_s.busy_counts = 1'b0;
				end
			end
			default: begin
				next_s.st = BUSY_IDLE;
			end
		endcase

		// Write period: own writes, plus every free-select busy issued while armed by a start
		if (s.active && write_active_in && !s.excl_write) begin
			next_s.sub_period = s.sub_period + 32'h00000001;
		end else if (s.st == BUSY_HOLD && s.busy_counts) begin
			next_s.sub_period = s.sub_period + 32'h00000001;
		end
		if (!write_active_in) begin
			next_s.excl_write = 1'b0;
		end

		// Command decode
		if (cmd_valid_in) begin
			if (cmd_index_in == `SR_CMD_RECORD) begin
				next_s.st          = BUSY_HOLD;
				next_s.busy_cnt    = 28'h0000000;
				next_s.busy_lim    = fn_limit(cmd_function_in);
				next_s.busy_counts = 1'b0;
				case (cmd_function_in)
					FN_START: begin
						next_s.armed = 1'b1;
					end
					FN_DIR: begin
						next_s.assoc = ASSOC_DIR;
					end
					FN_INFO: begin
						next_s.assoc = ASSOC_INFO;
					end
					FN_PAUSE: begin
						next_s.active = 1'b0;
					end
					FN_FREE: begin
						next_s.active      = 1'b1;
						next_s.unit_base   = cmd_addr_in & ~UNIT_MASK;
						next_s.wr_ptr      = cmd_addr_in & ~UNIT_MASK;
						next_s.first_sub   = s.armed;
						next_s.busy_counts = s.armed;
						next_s.sub_period  = 32'h00000000;
						next_s.sub_invalid = 1'b0;
					end
					default: begin
						next_s.armed = s.armed;
					end
				endcase
				if (cmd_function_in == FN_START || cmd_function_in == FN_FREE) begin
					next_s.busy_counts = (cmd_function_in == FN_FREE) && s.armed;
				end
			end else if (is_violating(cmd_index_in)) begin
				next_s.active = 1'b0;
				next_s.armed  = 1'b0;
			end else if (cmd_index_in == `SR_CMD_STOP) begin
				if (s.active && (s.wr_ptr & REC_MASK) != 32'h00000000) begin
					next_s.sub_invalid = 1'b1;
				end
			end
			if (read_active_in && cmd_index_in != `SR_CMD_RD_SINGLE &&
				cmd_index_in != `SR_CMD_RD_MULTI && cmd_index_in != `SR_CMD_STOP) begin
				next_s.rd_invalid = 1'b1;
			end
		end

		// Block writes: associated writes, then sequential recording writes
		if (write_block_in) begin
			if (s.assoc != ASSOC_NONE) begin
				next_s.assoc      = ASSOC_NONE;
				next_s.excl_write = 1'b1;
				next_s.st         = BUSY_HOLD;
				next_s.busy_cnt   = 28'h0000000;
				if (s.assoc == ASSOC_DIR) begin
					next_s.busy_lim = ext_capacity_in ? DIR_WR_XC_CYC : DIR_WR_HC_CYC;
				end else begin
					next_s.busy_lim = INFO_WR_CYCLES;
				end
			end else if (s.active) begin
				if (write_addr_in == s.wr_ptr) begin
					next_s.wr_ptr = s.wr_ptr + 32'h00000001;
					if ((write_addr_in & SUB_MASK) == SUB_MASK) begin
						if (!next_s.sub_invalid && !fs_unit_in &&
							next_s.sub_period > s.worst_wr) begin
							next_s.worst_wr = next_s.sub_period;
						end
						next_s.sub_period  = 32'h00000000;
						// A stop in this same cycle marks the next sub-unit only when no earlier stop marked this one
						next_s.sub_invalid = next_s.sub_invalid && !s.sub_invalid;
						next_s.first_sub   = 1'b0;
					end
					if ((write_addr_in & UNIT_MASK) == UNIT_MASK) begin
						next_s.active = 1'b0;
					end
				end else begin
					next_s.active = 1'b0;
				end
			end
		end

		// Block reads: position within the active unit, and read period per sub-unit
		if (read_block_in) begin
			in_unit = s.active && ((read_addr_in & ~UNIT_MASK) == s.unit_base);
			next_s.rd_written   = in_unit && (read_addr_in < s.wr_ptr);
			next_s.rd_undefined = in_unit && (read_addr_in >= s.wr_ptr);
			rd_off = read_addr_in & SUB_MASK;
			if (rd_off == SUB_MASK) begin
				if (!s.rd_invalid && !fs_unit_in && next_s.rd_period > s.worst_rd) begin
					next_s.worst_rd = next_s.rd_period;
				end
				next_s.rd_period  = 32'h00000000;
				next_s.rd_invalid = 1'b0;
			end
		end
		if (read_active_in && !fs_unit_in) begin
			next_s.rd_period = next_s.rd_period + 32'h00000001;
		end

		// File-system read time watch
		if (fs_read_active_in) begin
			if (s.fs_cnt != FS_READ_CYCLES) begin
				next_s.fs_cnt = s.fs_cnt + 28'h0000001;
			end else begin
				next_s.fs_late = 1'b1;
			end
		end else begin
			next_s.fs_cnt = 28'h0000000;
		end

		next_s.class_ok = (`SR_CLASS_VALUE * {32'h00000000, s.worst_wr}) <=
			(`SR_SUB_MB * `SR_CLK_HZ);
		next_s.read_ok  = (s.worst_rd <= s.worst_wr);
	end

	always_ff @(posedge ref_clk_in) begin
		if (!reset_n_in) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
endmodule : stream_record_timing
`default_nettype wire

// ===== verilog/stream_word_if.sv
// Word stream carrier between the recording block and its buffer
`timescale 1ns/10ps
`default_nettype none
interface stream_word_if;
	logic [31:0] data;
	logic        valid;
	logic        ready;
	modport source (output data, output valid, input ready);
	modport sink   (input data, input valid, output ready);
endinterface : stream_word_if
`default_nettype wire

// ===== verilog/word_buffer.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module word_buffer
	import stream_record_pkg::*;
(
	input  wire logic    ref_clk_in,
	input  wire logic    reset_n_in,
	stream_word_if.sink   fill,
	stream_word_if.source drain
);
	buffer_state_s s;
	buffer_state_s next_s;
	logic          push;
	logic          pop;

	assign fill.ready  = (s.count != 2'd2);
	assign drain.valid = (s.count != 2'd0);
	assign drain.data  = s.word0;
	assign push        = fill.valid && fill.ready;
	assign pop         = drain.valid && drain.ready;

	always_comb begin
		next_s = s;
		if (pop) begin
			next_s.word0 = s.word1;
		end
		if (push) begin
			if (s.count == 2'd0 || (s.count == 2'd1 && pop)) begin
				next_s.word0 = fill.data;
			end else begin
				next_s.word1 = fill.data;
			end
		end
		next_s.count = s.count + {1'b0, push} - {1'b0, pop};
	end

	always_ff @(posedge ref_clk_in) begin
		if (!reset_n_in) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
endmodule : word_buffer
`default_nettype wire
